// File: psf_pin_mux.sv
// Purpose: Pin function multiplexer with per-pin config and input steering.
// Assumes: Pad inputs are asynchronous and are synchronised here.
// Notes: Registers are reached over AXI4-Lite; unmapped addresses answer SLVERR.
// Overview of operation
// - The two-bit alternate-function field picks output slot 0 to 3 as 00, 01, 10, 11.
// - A pin feeds input functions other than the NMI only while its input buffer enable bit is 1; the NMI input ignores it.
// - Input-only functions own no field code; the field steers outputs only.
// - Each pin input goes to every module that listens to it at once.
// - Shared module inputs take their pad from the source pad select fields.
// - A pin chosen as the non-maskable interrupt source ignores its field.
// - Every wakeup pin is also usable as an external interrupt input.
// - Boot-only functions are enabled during boot and never via the field.
// - The unit scales to 32 ports of 16 I/O bits and 32 external interrupts.
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module psf_pin_mux
    import psf_pkg::*;
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave.
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Boot phase level from the system.
    input wire logic boot_active,
    // Peripheral output function slots, one bit per pin per slot.
    input wire logic [PSF_NPINS-1:0] func_slot_0,
    input wire logic [PSF_NPINS-1:0] func_slot_1,
    input wire logic [PSF_NPINS-1:0] func_slot_2,
    input wire logic [PSF_NPINS-1:0] func_slot_3,
    input wire logic [PSF_NPINS-1:0] func_slot_oe_0,
    input wire logic [PSF_NPINS-1:0] func_slot_oe_1,
    input wire logic [PSF_NPINS-1:0] func_slot_oe_2,
    input wire logic [PSF_NPINS-1:0] func_slot_oe_3,
    // Boot-time function drive.
    input wire logic [PSF_NPINS-1:0] boot_func_out,
    input wire logic [PSF_NPINS-1:0] boot_func_oe,
    // Pads.
    input wire logic [PSF_NPINS-1:0] pad_in,
    output logic [PSF_NPINS-1:0] pad_out,
    output logic [PSF_NPINS-1:0] pad_oe,
    // Inputs distributed to modules.
    output logic [PSF_NPINS-1:0] pin_input,
    output logic [PSF_NSEL-1:0] steered_input,
    output logic nmi_input,
    output logic [PSF_NPINS-1:0] ext_irq_input
);
    logic [PSF_NPINS-1:0] pad_meta;
    logic [PSF_NPINS-1:0] pad_sync;
    logic [1:0] alt_func_field [PSF_NPINS];
    logic [PSF_NPINS-1:0] input_buffer_en;
    logic [PSF_NPINS-1:0] gpio_oe;
    logic [PSF_NSEL*PSF_SEL_W-1:0] input_steer_reg;
    logic [PSF_PIN_W-1:0] nmi_pin;
    logic nmi_en;
    logic [PSF_NPINS-1:0] boot_func_en;
    logic [PSF_NPINS-1:0] next_pad_out;
    logic [PSF_NPINS-1:0] next_pad_oe;
    logic [11:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_held;
    logic do_write;
    logic [PSF_PIN_W-1:0] w_pin;
    logic w_is_cfg;
    logic [PSF_PIN_W-1:0] r_pin;

    // Two flops on every pad before any logic looks at it.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pad_meta <= '0;
            pad_sync <= '0;
        end
        else
        begin
            pad_meta <= pad_in;
            pad_sync <= pad_meta;
        end
    end

    // Write channel capture: address and data are accepted in either order.
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign w_pin = aw_addr[PSF_PIN_W+1:2];
    assign w_is_cfg = aw_addr[11:PSF_PIN_W+2] == PSF_CFG_BASE[11:PSF_PIN_W+2];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end
        else if (do_write)
        begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
        else if (do_write)
        begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= PSF_RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            if (w_is_cfg || aw_addr == PSF_STEER_OFS || aw_addr == PSF_NMI_OFS
                || aw_addr == PSF_BOOT_OFS)
                s_axi_bresp <= PSF_RESP_OKAY;
            else
                s_axi_bresp <= PSF_RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Per-pin configuration: field, input enable, GPIO output enable.
    genvar gi;
    generate
        for (gi = 0; gi < PSF_NPINS; gi++)
        begin : g_cfg
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    alt_func_field[gi] <= PSF_AF_RST;
                    input_buffer_en[gi] <= PSF_DBG_PINS[gi];
                    gpio_oe[gi] <= 1'b0;
                end
                else if (do_write && w_is_cfg && w_pin == PSF_PIN_W'(gi))
                begin
                    if (w_strb[0])
                        alt_func_field[gi] <= w_data[PSF_AF_LSB +: 2];
                    if (w_strb[1])
                    begin
                        input_buffer_en[gi] <= w_data[PSF_IBE_BIT];
                        gpio_oe[gi] <= w_data[PSF_OBE_BIT];
                    end
                end
            end

            // Output path: boot function, then NMI, then field-selected slot.
            always_comb
            begin
                next_pad_out[gi] = 1'b0;
                next_pad_oe[gi] = 1'b0;
                if (boot_active && boot_func_en[gi])
                begin
                    next_pad_out[gi] = boot_func_out[gi];
                    next_pad_oe[gi] = boot_func_oe[gi];
                end
                else if (nmi_en && nmi_pin == PSF_PIN_W'(gi))
                begin
                    next_pad_out[gi] = 1'b0;
                    next_pad_oe[gi] = 1'b0;
                end
                else
                begin
                    unique case (alt_func_field[gi])
                        PSF_SLOT_0:
                        begin
                            next_pad_out[gi] = func_slot_0[gi];
                            next_pad_oe[gi] = gpio_oe[gi];
                        end
                        PSF_SLOT_1:
                        begin
                            next_pad_out[gi] = func_slot_1[gi];
                            next_pad_oe[gi] = func_slot_oe_1[gi];
                        end
                        PSF_SLOT_2:
                        begin
                            next_pad_out[gi] = func_slot_2[gi];
                            next_pad_oe[gi] = func_slot_oe_2[gi];
                        end
                        PSF_SLOT_3:
                        begin
                            next_pad_out[gi] = func_slot_3[gi];
                            next_pad_oe[gi] = func_slot_oe_3[gi];
                        end
                    endcase
                end
            end

            // Input gating by the buffer enable alone, fanned out to all listeners.
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    pin_input[gi] <= 1'b0;
                else
                    pin_input[gi] <= pad_sync[gi] & input_buffer_en[gi];
            end
        end
    endgenerate

    // Slot 0 OE for the GPIO function comes from software; slot 0 peripheral OE unused.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pad_out <= '0;
            pad_oe <= '0;
        end
        else
        begin
            pad_out <= next_pad_out;
            pad_oe <= next_pad_oe;
        end
    end

    // Steering, NMI and boot-enable registers.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            input_steer_reg <= PSF_STEER_RST;
            nmi_en <= 1'b0;
            nmi_pin <= '0;
            boot_func_en <= '0;
        end
        else if (do_write && w_strb[0])
        begin
            if (aw_addr == PSF_STEER_OFS)
                input_steer_reg <= w_data[PSF_NSEL*PSF_SEL_W-1:0];
            if (aw_addr == PSF_NMI_OFS)
            begin
                nmi_pin <= w_data[PSF_PIN_W-1:0];
                nmi_en <= w_data[PSF_NMI_EN_BIT];
            end
            if (aw_addr == PSF_BOOT_OFS && boot_active)
                boot_func_en <= w_data[PSF_NPINS-1:0];
        end
    end

    // Shared inputs: source pad select picks one of four pads per module.
    genvar si;
    generate
        for (si = 0; si < PSF_NSEL; si++)
        begin : g_steer
            logic [PSF_SEL_W-1:0] source_pad_select;
            assign source_pad_select = input_steer_reg[si*PSF_SEL_W +: PSF_SEL_W];
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    steered_input[si] <= 1'b0;
                else
                    steered_input[si] <= pad_sync[{source_pad_select, PSF_SEL_W'(si)}]
                        & input_buffer_en[{source_pad_select, PSF_SEL_W'(si)}];
            end
        end
    endgenerate

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            nmi_input <= 1'b0;
            ext_irq_input <= '0;
        end
        else
        begin
            nmi_input <= nmi_en & pad_sync[nmi_pin];
            ext_irq_input <= pad_sync & input_buffer_en;
        end
    end

    // Read channel.
    assign s_axi_arready = !s_axi_rvalid;
    assign r_pin = s_axi_araddr[PSF_PIN_W+1:2];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= PSF_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= PSF_RESP_OKAY;
            s_axi_rdata <= '0;
            if (s_axi_araddr[11:PSF_PIN_W+2] == PSF_CFG_BASE[11:PSF_PIN_W+2])
            begin
                s_axi_rdata[PSF_AF_LSB +: 2] <= alt_func_field[r_pin];
                s_axi_rdata[PSF_IBE_BIT] <= input_buffer_en[r_pin];
                s_axi_rdata[PSF_OBE_BIT] <= gpio_oe[r_pin];
            end
            else if (s_axi_araddr == PSF_STEER_OFS)
                s_axi_rdata[PSF_NSEL*PSF_SEL_W-1:0] <= input_steer_reg;
            else if (s_axi_araddr == PSF_NMI_OFS)
            begin
                s_axi_rdata[PSF_PIN_W-1:0] <= nmi_pin;
                s_axi_rdata[PSF_NMI_EN_BIT] <= nmi_en;
            end
            else if (s_axi_araddr == PSF_BOOT_OFS)
                s_axi_rdata[PSF_NPINS-1:0] <= boot_func_en;
            else if (s_axi_araddr == PSF_PADIN_OFS)
                s_axi_rdata[PSF_NPINS-1:0] <= pad_sync;
            else if (s_axi_araddr == PSF_INFO_OFS)
                s_axi_rdata <= {8'(PSF_MAX_EXT_IRQ), 8'(PSF_PORT_BITS), 8'(PSF_MAX_PORTS),
                    8'(PSF_NPINS)};
            else
                s_axi_rresp <= PSF_RESP_SLVERR;
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Checks.
    af_slot_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!boot_active && !nmi_en && alt_func_field[0] == PSF_SLOT_1)
        |=> pad_out[0] == $past(func_slot_1[0])) else $error("slot 1 not routed");
    ibe_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !input_buffer_en[0] |=> !pin_input[0]) else $error("input leaked");
    nmi_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!boot_active && nmi_en && nmi_pin == 4'h0) |=> !pad_oe[0])
        else $error("nmi pin driven");
    steer_src_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (input_steer_reg[1:0] == 2'h3 && input_buffer_en[12])
        |=> steered_input[0] == $past(pad_sync[12])) else $error("steer wrong");
    wake_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
        input_buffer_en[0] |=> ext_irq_input[0] == $past(pad_sync[0]))
        else $error("irq path wrong");
    boot_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!boot_active && !nmi_en && alt_func_field[1] == PSF_SLOT_0)
        |=> pad_oe[1] == $past(gpio_oe[1])) else $error("boot leak");
    reset_af_a: assert property (@(posedge aclk)
        !aresetn |=> alt_func_field[0] == PSF_SLOT_0 && !input_buffer_en[0]
        && input_buffer_en[15]) else $error("reset state wrong");
    bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
    write_cv: cover property (@(posedge aclk) do_write && w_is_cfg);
    read_cv: cover property (@(posedge aclk) s_axi_rvalid && s_axi_rready);
    nmi_cv: cover property (@(posedge aclk) nmi_input);
endmodule

// File: psf_pkg.sv
// Purpose: Shared constants for the port pin function select block.
// Assumes: AXI4-Lite register access, 32-bit data, word-aligned registers.
// Notes: Pin count is reduced from the architectural maximum to keep area modest.
package psf_pkg;
    // Architectural limits of the integration unit.
    localparam int PSF_MAX_PORTS = 32;
    localparam int PSF_PORT_BITS = 16;
    localparam int PSF_MAX_EXT_IRQ = 32;
    // Implemented pins and derived widths.
    localparam int PSF_NPINS = 16;
    localparam int PSF_PIN_W = 4;
    localparam int PSF_NSEL = 4;
    localparam int PSF_SEL_W = 2;
    // Register offsets (byte addresses).
    localparam logic [11:0] PSF_CFG_BASE = 12'h000;
    localparam logic [11:0] PSF_STEER_OFS = 12'h100;
    localparam logic [11:0] PSF_NMI_OFS = 12'h104;
    localparam logic [11:0] PSF_BOOT_OFS = 12'h108;
    localparam logic [11:0] PSF_PADIN_OFS = 12'h10c;
    localparam logic [11:0] PSF_INFO_OFS = 12'h110;
    // Per-pin configuration register fields.
    localparam int PSF_AF_LSB = 0;
    localparam int PSF_IBE_BIT = 8;
    localparam int PSF_OBE_BIT = 9;
    // NMI select register fields.
    localparam int PSF_NMI_EN_BIT = 8;
    // Reset values.
    localparam logic [1:0] PSF_AF_RST = 2'h0;
    localparam logic [PSF_NPINS-1:0] PSF_DBG_PINS = 16'hc000;
    localparam logic [PSF_NSEL*PSF_SEL_W-1:0] PSF_STEER_RST = 8'h00;
    // Function slot codes.
    localparam logic [1:0] PSF_SLOT_0 = 2'h0;
    localparam logic [1:0] PSF_SLOT_1 = 2'h1;
    localparam logic [1:0] PSF_SLOT_2 = 2'h2;
    localparam logic [1:0] PSF_SLOT_3 = 2'h3;
    // AXI responses.
    localparam logic [1:0] PSF_RESP_OKAY = 2'h0;
    localparam logic [1:0] PSF_RESP_SLVERR = 2'h2;
endpackage

// File: tb_psf_pin_mux.sv
// Purpose: Self-checking bench for the port pin function select block.
// Assumes: Register access over AXI4-Lite; pad path settles within five cycles.
// Notes: Signals are driven by non-blocking assignment after a rising edge.
`timescale 1ns/1ps
module tb_top
    import psf_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic boot_active = 1'b0;
    logic [PSF_NPINS-1:0] func_slot_0 = '0, func_slot_1 = '0, func_slot_2 = '0;
    logic [PSF_NPINS-1:0] func_slot_3 = '0, func_slot_oe_0 = '0;
    logic [PSF_NPINS-1:0] func_slot_oe_1 = 16'hffff, func_slot_oe_2 = 16'hffff;
    logic [PSF_NPINS-1:0] func_slot_oe_3 = 16'hffff;
    logic [PSF_NPINS-1:0] boot_func_out = '0, boot_func_oe = '0, pad_in = '0;
    logic [PSF_NPINS-1:0] pad_out, pad_oe, pin_input, ext_irq_input;
    logic [PSF_NSEL-1:0] steered_input;
    logic nmi_input;
    int errors = 0;
    int checks = 0;
    int cycles = 0;
    logic [31:0] rd_data;
    logic [1:0] resp;

    psf_pin_mux psf_pin_mux_inst (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .boot_active, .func_slot_0, .func_slot_1,
        .func_slot_2, .func_slot_3, .func_slot_oe_0, .func_slot_oe_1,
        .func_slot_oe_2, .func_slot_oe_3, .boot_func_out, .boot_func_oe,
        .pad_in, .pad_out, .pad_oe, .pin_input, .steered_input, .nmi_input,
        .ext_irq_input
    );

    always #2.5 aclk = ~aclk;

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // A hang on the bus or in the sequence ends the run here.
    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            errors = errors + 1;
            final_report();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks = checks + 1;
        if (got !== exp)
        begin
            errors = errors + 1;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Handshake signals are read just before the edge that samples them.
    task automatic axi_write(input logic [11:0] addr, input logic [31:0] data);
        logic aw_done, w_done, a, w, b;
        aw_done = 1'b0;
        w_done = 1'b0;
        b = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= addr;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= data;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(negedge aclk);
            a = s_axi_awready;
            w = s_axi_wready;
            @(posedge aclk);
            if (!aw_done && a === 1'b1)
            begin
                s_axi_awvalid <= 1'b0;
                aw_done = 1'b1;
            end
            if (!w_done && w === 1'b1)
            begin
                s_axi_wvalid <= 1'b0;
                w_done = 1'b1;
            end
        end
        while (b !== 1'b1)
        begin
            @(negedge aclk);
            b = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge aclk);
        end
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [11:0] addr);
        logic a, r;
        a = 1'b0;
        r = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= addr;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (a !== 1'b1)
        begin
            @(negedge aclk);
            a = s_axi_arready;
            @(posedge aclk);
        end
        s_axi_arvalid <= 1'b0;
        while (r !== 1'b1)
        begin
            @(negedge aclk);
            r = s_axi_rvalid;
            rd_data = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge aclk);
        end
        s_axi_rready <= 1'b0;
    endtask

    task automatic settle();
        repeat (5) @(posedge aclk);
    endtask

    task automatic end_test(input string name);
        $display("Test %s finished, mismatches so far %0d", name, errors);
    endtask

    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_read(PSF_CFG_BASE);
        chk("cfg0 reset", 32'h0, rd_data);
        axi_read(PSF_CFG_BASE + 12'h038);
        chk("cfg14 reset", 32'h100, rd_data);
        axi_read(PSF_CFG_BASE + 12'h03c);
        chk("cfg15 reset", 32'h100, rd_data);
        chk("pad_oe reset", 32'h0, {16'h0, pad_oe});
        axi_read(PSF_INFO_OFS);
        chk("info", 32'h20102010, rd_data);
        axi_read(12'h200);
        chk("unmapped read resp", {30'h0, PSF_RESP_SLVERR}, {30'h0, resp});
        chk("unmapped read data", 32'h0, rd_data);
        axi_write(12'h200, 32'h1);
        chk("unmapped write resp", {30'h0, PSF_RESP_SLVERR}, {30'h0, resp});
        end_test("reset_and_map");
        for (int k = 0; k < 4; k++)
        begin
            @(posedge aclk);
            func_slot_0 <= (k == 0) ? 16'h0001 : 16'h0000;
            func_slot_1 <= (k == 1) ? 16'h0001 : 16'h0000;
            func_slot_2 <= (k == 2) ? 16'h0001 : 16'h0000;
            func_slot_3 <= (k == 3) ? 16'h0001 : 16'h0000;
            axi_write(PSF_CFG_BASE, (k == 0) ? 32'h200 : k);
            settle();
            chk("slot data pin0", 32'h1, {31'h0, pad_out[0]});
            chk("slot oe pin0", 32'h1, {31'h0, pad_oe[0]});
        end
        axi_write(PSF_CFG_BASE, 32'h0);
        settle();
        chk("gpio oe off", 32'h0, {31'h0, pad_oe[0]});
        end_test("slot_select");
        pad_in <= 16'hffff;
        settle();
        chk("pin_input gated", 32'hc000, {16'h0, pin_input});
        chk("ext_irq gated", 32'hc000, {16'h0, ext_irq_input});
        axi_write(PSF_CFG_BASE, 32'h103);
        settle();
        chk("pin_input af3", 32'hc001, {16'h0, pin_input});
        chk("ext_irq af3", 32'hc001, {16'h0, ext_irq_input});
        end_test("input_enable");
        pad_in <= 16'h1000;
        axi_write(PSF_CFG_BASE + 12'h030, 32'h100);
        axi_write(PSF_STEER_OFS, 32'h3);
        settle();
        chk("steer pad12", 32'h1, {28'h0, steered_input});
        axi_read(PSF_PADIN_OFS);
        chk("pad readback", 32'h1000, rd_data);
        axi_write(PSF_STEER_OFS, 32'h0);
        settle();
        chk("steer pad0", 32'h0, {28'h0, steered_input});
        end_test("steering");
        pad_in <= 16'h0001;
        settle();
        chk("af3 drives", 32'h1, {31'h0, pad_oe[0]});
        axi_write(PSF_NMI_OFS, 32'h100);
        settle();
        chk("nmi level", 32'h1, {31'h0, nmi_input});
        chk("nmi ignores field", 32'h0, {31'h0, pad_oe[0]});
        axi_write(PSF_NMI_OFS, 32'h0);
        settle();
        chk("nmi off", 32'h0, {31'h0, nmi_input});
        chk("field back", 32'h1, {31'h0, pad_oe[0]});
        end_test("nmi_priority");
        axi_write(PSF_BOOT_OFS, 32'h2);
        axi_read(PSF_BOOT_OFS);
        chk("boot locked", 32'h0, rd_data);
        boot_active <= 1'b1;
        boot_func_out <= 16'h0002;
        boot_func_oe <= 16'h0002;
        axi_write(PSF_BOOT_OFS, 32'h2);
        axi_read(PSF_BOOT_OFS);
        chk("boot write", 32'h2, rd_data);
        settle();
        chk("boot data pin1", 32'h1, {31'h0, pad_out[1]});
        chk("boot oe pin1", 32'h1, {31'h0, pad_oe[1]});
        boot_active <= 1'b0;
        settle();
        chk("boot released", 32'h0, {31'h0, pad_oe[1]});
        end_test("boot_functions");
        final_report();
    end
endmodule
